/* File: core/wdt_io_watchdog.sv */
// Overview of operation
// - Interval counts whole seconds, 1 to 255
// - Interval zero disables, no timeout possible
// - Countdown starts once nonzero interval written and device active
// - Each rewrite reloads the programmed interval
// - Expiry resets CPU or raises interrupt
`timescale 1ns/1ps
`default_nettype none

module wdt_io_watchdog #(
  parameter int unsigned TICK_CYCLES = wdt_pkg::CYCLES_PER_SEC,
  parameter int unsigned RST_PULSE   = wdt_pkg::RST_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Host I/O port cycles
  input  wire logic [wdt_pkg::IO_AW-1:0] io_addr_i,
  input  wire logic [7:0]               io_wdata_i,
  input  wire logic                     io_wr_i,
  input  wire logic                     io_rd_i,
  output logic      [7:0]               io_rdata_o,
  // Board strap: expiry raises interrupt instead of reset
  input  wire logic                     expire_irq_mode_i,
  // Expiry actions
  output logic                          cpu_reset_o,
  output logic                          irq_o
);
  import wdt_pkg::*;

  localparam int unsigned RW = $clog2(RST_PULSE + 1);

  wdt_cfg_e      cfg_state;
  logic [7:0]    index;
  logic [7:0]    ldn;
  logic          active;
  logic [7:0]    interval;
  logic [7:0]    count;
  logic [RW-1:0] rst_cnt;
  logic          mode_meta;
  logic          irq_mode;
  logic          tick;

  // Port decode
  wire wr_index  = io_wr_i && (io_addr_i == ADDR_INDEX);
  wire wr_data   = io_wr_i && (io_addr_i == ADDR_DATA);
  wire rd_index  = io_rd_i && (io_addr_i == ADDR_INDEX);
  wire rd_data   = io_rd_i && (io_addr_i == ADDR_DATA);
  wire cfg_open  = (cfg_state == CFG_OPEN);
  wire ldn_hit   = (ldn == WDT_LDN);
  wire wr_cfg    = wr_data && cfg_open;
  wire wr_ldn    = wr_cfg && (index == IDX_LDN);
  wire wr_act    = wr_cfg && ldn_hit && (index == IDX_ACTIVATE);
  wire wr_ivl    = wr_cfg && ldn_hit && (index == IDX_INTERVAL);
  wire is_enter  = (io_wdata_i == KEY_ENTER);
  wire is_exit   = (io_wdata_i == KEY_EXIT);

  // Unlock sequence: two enter keys in a row open, exit key closes
  wdt_cfg_e next_cfg_state;
  assign next_cfg_state =
    !wr_index                              ? cfg_state  :
    (cfg_state == CFG_LOCKED) && is_enter  ? CFG_HALF   :
    (cfg_state == CFG_HALF) && is_enter    ? CFG_OPEN   :
    (cfg_state == CFG_OPEN) && !is_exit    ? CFG_OPEN   :
                                             CFG_LOCKED;

  // Countdown runs only while the device is active and armed
  wire        dec_en     = tick && active && (count != 8'h00) && !wr_ivl;
  wire        expire_evt = dec_en && (count == 8'h01);
  wire [7:0]  next_count = wr_ivl ? io_wdata_i :
                           dec_en ? count - 8'h01 : count;

  // Expiry action: interrupt held until next interval write, or a reset pulse
  wire          next_irq     = (expire_evt && irq_mode) || (irq_o && !wr_ivl);
  wire [RW-1:0] next_rst_cnt = (expire_evt && !irq_mode) ? RW'(RST_PULSE) :
                               (rst_cnt != '0) ? rst_cnt - 1'b1 : rst_cnt;

  // Read mux; device registers hidden unless the watchdog device is selected
  wire [7:0] dev_sel =
    (index == IDX_LDN)               ? ldn :
    !ldn_hit                         ? IDLE_READ :
    (index == IDX_ACTIVATE)          ? {7'h00, active} :
    (index == IDX_INTERVAL)          ? interval :
    (index == IDX_REMAIN)            ? count : IDLE_READ;
  wire [7:0] next_rdata =
    rd_index && cfg_open ? index :
    rd_data && cfg_open  ? dev_sel : IDLE_READ;

  // One-second time base, restarted on each load so seconds are whole
  wdt_sec_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (wr_ivl),
    .tick_o  (tick)
  );

  // Strap comes from a pin, so it is synchronised first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_meta <= 1'b0;
      irq_mode  <= 1'b0;
    end else begin
      mode_meta <= expire_irq_mode_i;
      irq_mode  <= mode_meta;
    end
  end

  // Configuration state and index
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_state <= CFG_LOCKED;
      index     <= INDEX_RST;
    end else begin
      cfg_state <= next_cfg_state;
      if (wr_index && cfg_open && !is_exit) begin
        index <= io_wdata_i;
      end
    end
  end

  // Logical device select and activation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ldn    <= LDN_RST;
      active <= 1'b0;
    end else begin
      if (wr_ldn) begin
        ldn <= io_wdata_i;
      end
      if (wr_act) begin
        active <= io_wdata_i[ACT_BIT];
      end
    end
  end

  // Interval and countdown; a rewrite is also the refresh
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interval <= INTERVAL_RST;
      count    <= INTERVAL_RST;
    end else begin
      if (wr_ivl) begin
        interval <= io_wdata_i;
      end
      count <= next_count;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt     <= '0;
      cpu_reset_o <= 1'b0;
      irq_o       <= 1'b0;
      io_rdata_o  <= IDLE_READ;
    end else begin
      rst_cnt     <= next_rst_cnt;
      cpu_reset_o <= (next_rst_cnt != '0);
      irq_o       <= next_irq;
      io_rdata_o  <= next_rdata;
    end
  end

  // Checks
  chk_zero_disarms: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_ivl && io_wdata_i == 8'h00) |=> (count == 8'h00) && !expire_evt)
    else $error("zero interval did not disarm the countdown");

  chk_load_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ivl |=> (count == $past(io_wdata_i)) && (interval == $past(io_wdata_i)))
    else $error("interval write did not load the countdown");

  // A pulse already under way runs out on its own, so only a nearly idle pulse counter qualifies
  chk_refresh_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_ivl && io_wdata_i != 8'h00 && rst_cnt <= RW'(1)) |=> !expire_evt && !cpu_reset_o && !irq_o)
    else $error("refresh did not clear pending expiry");

  chk_step_second: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick && active && count > 8'h01 && !wr_ivl) |=> count == $past(count) - 8'h01)
    else $error("countdown did not step once per second");

  chk_no_early: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(irq_o) || $rose(cpu_reset_o)) |-> ($past(count) == 8'h01) && $past(tick))
    else $error("expiry before the last second ran out");

  chk_irq_expire: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (expire_evt && irq_mode) |=> irq_o && !cpu_reset_o)
    else $error("interrupt mode expiry did not raise interrupt");

  chk_reset_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (expire_evt && !irq_mode) |=> cpu_reset_o[*8])
    else $error("reset mode expiry did not hold the reset pulse");

  chk_open_needs_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_state == CFG_LOCKED) |=> cfg_state != CFG_OPEN)
    else $error("configuration opened on a single key");

  cov_irq_expiry: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    expire_evt && irq_mode);

  cov_reset_expiry: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    expire_evt && !irq_mode);

  cov_refresh_running: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ivl && count != 8'h00 && io_wdata_i != 8'h00);

  chk_irq_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_o && !wr_ivl) |=> irq_o)
    else $error("interrupt dropped before the interval was rewritten");

  // No automatic reload: a spent or disarmed countdown stays at zero
  chk_zero_stays: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (count == 8'h00 && !wr_ivl) |=> count == 8'h00)
    else $error("idle countdown moved without an interval write");

  cov_zero_disarm: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ivl && io_wdata_i == 8'h00 && count != 8'h00);

  cov_pulse_done: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(cpu_reset_o));

endmodule

`default_nettype wire

/* File: core/wdt_pkg.sv */
`default_nettype none

package wdt_pkg;

  // I/O decode of the index/data port pair
  localparam int unsigned IO_AW      = 16;
  localparam logic [15:0] ADDR_INDEX = 16'h002e;
  localparam logic [15:0] ADDR_DATA  = 16'h002f;

  // Keys written to the index port
  localparam logic [7:0] KEY_ENTER = 8'h87;
  localparam logic [7:0] KEY_EXIT  = 8'haa;

  // Configuration indices
  localparam logic [7:0] IDX_LDN      = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_INTERVAL = 8'hf6;
  localparam logic [7:0] IDX_REMAIN   = 8'hf7;

  // Logical device number of the watchdog, activate bit position
  localparam logic [7:0]  WDT_LDN      = 8'h08;
  localparam int unsigned ACT_BIT      = 0;

  // Reset values and the answer for anything not readable
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic [7:0] LDN_RST      = 8'h00;
  localparam logic [7:0] INDEX_RST    = 8'h00;
  localparam logic [7:0] IDLE_READ    = 8'hff;

  // Timing: clock rate, one-second time base, CPU reset pulse
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned TICK_PERIOD_MS   = 1000;
  localparam int unsigned CYCLES_PER_SEC   = (CLK_FREQ_HZ / 1000) * TICK_PERIOD_MS;
  localparam int unsigned RST_PULSE_NS     = 1000;
  localparam int unsigned RST_PULSE_CYCLES =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Unlock sequence states
  typedef enum logic [1:0] {CFG_LOCKED, CFG_HALF, CFG_OPEN} wdt_cfg_e;

endpackage

`default_nettype wire

/* File: core/wdt_sec_tick.sv */
`timescale 1ns/1ps
`default_nettype none

module wdt_sec_tick #(
  parameter int unsigned TICK_CYCLES = wdt_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Restart the second so a fresh interval gets full seconds
  input  wire logic clear_i,
  // One-cycle pulse per second
  output logic      tick_o
);
  import wdt_pkg::*;

  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt;
  wire           wrap = (cnt == LAST);

  // Free-running divider, restarted by clear_i
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= wrap ? '0 : cnt + 1'b1;
      tick_o <= wrap;
    end
  end

  chk_tick_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_o |=> !tick_o)
    else $error("second tick lasted more than one cycle");

endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import wdt_pkg::*;

  // Short second keeps the run brief; pulse length at the checked minimum
  localparam int unsigned T = 40;
  localparam int unsigned P = 8;

  logic        clk_i             = 1'b0;
  logic        rst_n_i           = 1'b0;
  logic [15:0] io_addr_i         = 16'h0000;
  logic [7:0]  io_wdata_i        = 8'h00;
  logic        io_wr_i           = 1'b0;
  logic        io_rd_i           = 1'b0;
  logic        expire_irq_mode_i = 1'b1;
  logic [7:0]  io_rdata_o;
  logic        cpu_reset_o;
  logic        irq_o;
  int          fails             = 0;
  int          n_tests           = 0;
  int          cyc               = 0;

  wdt_io_watchdog #(.TICK_CYCLES(T), .RST_PULSE(P)) uut (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .io_addr_i         (io_addr_i),
    .io_wdata_i        (io_wdata_i),
    .io_wr_i           (io_wr_i),
    .io_rd_i           (io_rd_i),
    .io_rdata_o        (io_rdata_o),
    .expire_irq_mode_i (expire_irq_mode_i),
    .cpu_reset_o       (cpu_reset_o),
    .irq_o             (irq_o)
  );

  // Clock, 20 ns period
  always #10 clk_i = ~clk_i;

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One I/O write; an idle cycle follows so the strobe is never re-raised at once
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr_i  = a;
    io_wdata_i = d;
    io_wr_i    = 1'b1;
    @(negedge clk_i);
    io_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Read data is registered, so it is valid at the following falling edge
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    io_addr_i = a;
    io_rd_i   = 1'b1;
    @(negedge clk_i);
    q       = io_rdata_o;
    io_rd_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wr(ADDR_INDEX, idx);
    rd(ADDR_DATA, q);
    chk(q, exp);
  endtask

  task automatic open_cfg();
    wr(ADDR_INDEX, KEY_ENTER);
    wr(ADDR_INDEX, KEY_ENTER);
    wr(ADDR_INDEX, IDX_LDN);
    wr(ADDR_DATA, WDT_LDN);
    wr(ADDR_INDEX, IDX_ACTIVATE);
    wr(ADDR_DATA, 8'h01);
  endtask

  task automatic set_iv(input logic [7:0] v);
    open_cfg();
    wr(ADDR_INDEX, IDX_INTERVAL);
    wr(ADDR_DATA, v);
    wr(ADDR_INDEX, KEY_EXIT);
  endtask

  // Locked port answers idle; open port shows its selection; interval resets to zero
  task automatic t_locked();
    logic [7:0] q;
    rd(ADDR_DATA, q);
    chk(q, IDLE_READ);
    open_cfg();
    rreg(IDX_LDN, WDT_LDN);
    rreg(IDX_ACTIVATE, 8'h01);
    rd(ADDR_INDEX, q);
    chk(q, IDX_ACTIVATE);
    rreg(IDX_INTERVAL, INTERVAL_RST);
    wr(ADDR_INDEX, KEY_EXIT);
  endtask

  // Three seconds, then a data write after exit must be ignored
  task automatic t_expire_irq();
    set_iv(8'h03);
    open_cfg();
    rreg(IDX_INTERVAL, 8'h03);
    rreg(IDX_REMAIN, 8'h03);
    wr(ADDR_INDEX, KEY_EXIT);
    wr(ADDR_DATA, 8'h00);
    wait_cyc(3 * T - 32);
    chk({7'h0, irq_o}, 8'h00);
    wait_cyc(8);
    chk({7'h0, irq_o}, 8'h01);
    chk({7'h0, cpu_reset_o}, 8'h00);
  endtask

  // A rewrite before expiry restarts the full interval
  task automatic t_refresh();
    set_iv(8'h02);
    chk({7'h0, irq_o}, 8'h00);
    wait_cyc(2 * T - 30);
    set_iv(8'h02);
    wait_cyc(2 * T - 10);
    chk({7'h0, irq_o}, 8'h00);
    wait_cyc(12);
    chk({7'h0, irq_o}, 8'h01);
  endtask

  // Largest interval, then a one-second interval disarmed before it runs out
  task automatic t_zero();
    set_iv(8'hff);
    open_cfg();
    rreg(IDX_REMAIN, 8'hff);
    wr(ADDR_INDEX, KEY_EXIT);
    set_iv(8'h01);
    set_iv(8'h00);
    wait_cyc(4 * T);
    chk({7'h0, irq_o}, 8'h00);
    chk({7'h0, cpu_reset_o}, 8'h00);
    open_cfg();
    rreg(IDX_REMAIN, 8'h00);
    wr(ADDR_INDEX, KEY_EXIT);
  endtask

  // Strap low: one second, then a reset pulse of P cycles
  task automatic t_reset_mode();
    int n;
    expire_irq_mode_i = 1'b0;
    wait_cyc(3);
    set_iv(8'h01);
    n = 0;
    while (cpu_reset_o !== 1'b1 && n < 2 * T) begin
      @(negedge clk_i);
      n++;
    end
    chk({7'h0, cpu_reset_o}, 8'h01);
    n = 0;
    while (cpu_reset_o === 1'b1 && n < 4 * P) begin
      @(negedge clk_i);
      n++;
    end
    chk(n[7:0], 8'(P));
    chk({7'h0, irq_o}, 8'h00);
  endtask

  // Reset in mid-count: port locked again, interval and countdown back to zero
  task automatic t_mid_reset();
    logic [7:0] q;
    set_iv(8'h02);
    rst_n_i = 1'b0;
    wait_cyc(2);
    rst_n_i = 1'b1;
    rd(ADDR_DATA, q);
    chk(q, IDLE_READ);
    open_cfg();
    rreg(IDX_INTERVAL, INTERVAL_RST);
    rreg(IDX_REMAIN, 8'h00);
    wr(ADDR_INDEX, KEY_EXIT);
  endtask

  // Reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    wait_cyc(3);
    chk(io_rdata_o, IDLE_READ);
    t_locked();
    t_expire_irq();
    t_refresh();
    t_zero();
    t_reset_mode();
    t_mid_reset();
    give_verdict();
  end

endmodule

`default_nettype wire
